// ---- rtl/eiu_top.sv ----
/*
  External pin interrupt unit: dedicated pin with sense control, two
  groups of eight pin-change inputs, flags, masks and vector select.
  Assumes a core that acknowledges vectored requests by one-cycle pulses,
  and pins that arrive asynchronously to ref_clk.
*/
// Notes on behaviour
// [R1] Toggle in enabled group raises group request
// [R2] Detection works whether pins are outputs
// [R3] Pin-change detection needs no running clock
// [R4] Sense field: low, any, falling, rising
// [R5] Low level requests while pin stays low
// [R6] Edge detection runs on the clock
// [R7] Pin sampled; pulses over one period caught
// [R8] Source holds low level until instruction ends
// [R9] Wake level held past start-up time
// [R10] Dedicated request needs enable bit and global
// [R11] Group requests need group enable and global
// [R12] Mask bit enables its own input
// [R13] Events set flags at bits 7,6,0
// [R14] Flags clear on service or written one
// [R15] Level mode keeps dedicated flag cleared
// [R16] Vector select picks flash start or boot
// [R17] Unlock cleared after four cycles or select
// [R18] Unlock blocks interrupts, global flag untouched
// [R19] Group request is OR of masked toggles
`include "eiu_params.svh"
`default_nettype none
module eiu_top
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Pins, read whatever their direction
  input  wire logic        dedicated_irq_pin,
  input  wire logic [15:0] pin_change_inputs,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Core side
  input  wire logic        global_irq_enable,
  input  wire logic        ack_dedicated,
  input  wire logic        ack_group_low,
  input  wire logic        ack_group_high,
  output logic             req_dedicated,
  output logic             pin_change_group_low_request,
  output logic             pin_change_group_high_request,
  output logic             vector_table_select,
  output logic             irq_blocked,
  // Clockless wake indication
  output logic             wake_request
);
  logic [7:0]  enable_mask_r;
  logic [1:0]  sense_r;
  logic [7:0]  mask_low_r;
  logic [7:0]  mask_high_r;
  logic        flag_ded_r;
  logic        flag_low_r;
  logic        flag_high_r;
  logic        vec_sel_r;
  logic        unlock_r;
  logic [2:0]  unlock_cnt_r;
  logic        tail_r;
  eiu_pkg::eiu_vstate_t vstate_r;
  logic        ded_meta_r;
  logic        ded_sync_r;
  logic        ded_prev_r;
  logic [15:0] pc_meta_r;
  logic [15:0] pc_sync_r;
  logic        ded_event;
  logic        low_level;
  logic        wr_flags;
  logic        wr_core;
  logic [7:0]  rdata_nxt;
  eiu_pkg::eiu_sense_t sense;

  eiu_pc_if pc_lo ();
  eiu_pc_if pc_hi ();

  // Register write decode shared by several processes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = reg_wr && (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Dedicated pin synchroniser; reset to idle high, so no false edge [R7]
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ded_meta_r <= 1'b1;
      ded_sync_r <= 1'b1;
      ded_prev_r <= 1'b1;
    end
    else
    begin
      ded_meta_r <= dedicated_irq_pin;
      ded_sync_r <= ded_meta_r;
      ded_prev_r <= ded_sync_r;
    end
  end

  // Pin-change synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      pc_meta_r <= 16'h0000;
      pc_sync_r <= 16'h0000;
    end
    else
    begin
      pc_meta_r <= pin_change_inputs;
      pc_sync_r <= pc_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin-change groups, bits 7..0 low and 15..8 high [R1] [R2]
  assign pc_lo.pins_sync    = pc_sync_r[7:0];
  assign pc_lo.mask         = mask_low_r;
  assign pc_lo.group_enable = enable_mask_r[`EIU_BIT_GROUP_LOW];
  assign pc_hi.pins_sync    = pc_sync_r[15:8];
  assign pc_hi.mask         = mask_high_r;
  assign pc_hi.group_enable = enable_mask_r[`EIU_BIT_GROUP_HIGH];

  // Raw pins enter only for the clockless wake compare
  eiu_pc_group u_group_low
  (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .pins_raw (pin_change_inputs[7:0]),
    .pins_ref (pc_sync_r[7:0]),
    .pc       (pc_lo)
  );

  eiu_pc_group u_group_high
  (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .pins_raw (pin_change_inputs[15:8]),
    .pins_ref (pc_sync_r[15:8]),
    .pc       (pc_hi)
  );

  ////////////////////////////////////////////////////////////////////////
  // Dedicated pin sense decode on sampled values [R4] [R6] [R7]
  assign sense     = eiu_pkg::eiu_sense_t'(sense_r);
  assign low_level = (sense == eiu_pkg::EIU_SENSE_LOW);

  always_comb
  begin
    case (sense)
      eiu_pkg::EIU_SENSE_ANY:     ded_event = ded_sync_r ^ ded_prev_r;
      eiu_pkg::EIU_SENSE_FALLING: ded_event = ded_prev_r & ~ded_sync_r;
      eiu_pkg::EIU_SENSE_RISING:  ded_event = ~ded_prev_r & ded_sync_r;
      default:                    ded_event = 1'b0;
    endcase
  end

  // Wake is clockless: raw low level or raw pin-change compare [R3] [R5]
  assign wake_request = (low_level & enable_mask_r[`EIU_BIT_DEDICATED] & ~dedicated_irq_pin)
                      | pc_lo.async_wake | pc_hi.async_wake;

  ////////////////////////////////////////////////////////////////////////
  // Enable mask keeps only the group and dedicated bits [R10] [R11]
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      enable_mask_r <= `EIU_RST_BYTE;
    else if (hit(reg_addr, `EIU_OFS_ENABLE_MASK))
      enable_mask_r <= reg_wdata & 8'hc1;
  end

  // Sense field of the dedicated pin [R4]
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      sense_r <= 2'h0;
    else if (hit(reg_addr, `EIU_OFS_SENSE_CONTROL))
      sense_r <= reg_wdata[1:0];
  end

  // Per-input mask of the low group
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      mask_low_r <= `EIU_RST_BYTE;
    else if (hit(reg_addr, `EIU_OFS_PC_MASK_LOW))
      mask_low_r <= reg_wdata; // [R12]
  end

  // Per-input mask of the high group
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      mask_high_r <= `EIU_RST_BYTE;
    else if (hit(reg_addr, `EIU_OFS_PC_MASK_HIGH))
      mask_high_r <= reg_wdata; // [R12]
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: set wins over clear; clear by service or written one [R13] [R14]
  assign wr_flags = hit(reg_addr, `EIU_OFS_FLAGS);

  // Dedicated flag; level sensing overrides everything
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      flag_ded_r <= 1'b0;
    else if (low_level)
      flag_ded_r <= 1'b0; // [R15]
    else if (ded_event)
      flag_ded_r <= 1'b1; // [R13]
    else if (ack_dedicated || (wr_flags && reg_wdata[`EIU_BIT_DEDICATED]))
      flag_ded_r <= 1'b0; // [R14]
  end

  // Low group flag
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      flag_low_r <= 1'b0;
    else if (pc_lo.toggle)
      flag_low_r <= 1'b1; // [R13]
    else if (ack_group_low || (wr_flags && reg_wdata[`EIU_BIT_GROUP_LOW]))
      flag_low_r <= 1'b0; // [R14]
  end

  // High group flag
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      flag_high_r <= 1'b0;
    else if (pc_hi.toggle)
      flag_high_r <= 1'b1; // [R13]
    else if (ack_group_high || (wr_flags && reg_wdata[`EIU_BIT_GROUP_HIGH]))
      flag_high_r <= 1'b0; // [R14]
  end

  ////////////////////////////////////////////////////////////////////////
  // Vector select with timed unlock [R16] [R17]
  assign wr_core = hit(reg_addr, `EIU_OFS_CORE_CONTROL);

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      vec_sel_r    <= 1'b0;
      unlock_r     <= 1'b0;
      unlock_cnt_r <= 3'h0;
      tail_r       <= 1'b0;
      vstate_r     <= eiu_pkg::EIU_VS_IDLE;
    end
    else
    begin
      case (vstate_r)
        eiu_pkg::EIU_VS_IDLE:
        begin
          tail_r <= 1'b0;
          if (wr_core && reg_wdata[`EIU_BIT_UNLOCK])
          begin
            unlock_r     <= 1'b1;
            unlock_cnt_r <= `EIU_UNLOCK_CYCLES;
            vstate_r     <= eiu_pkg::EIU_VS_OPEN;
          end
        end
        eiu_pkg::EIU_VS_OPEN:
        begin
          if (wr_core && !reg_wdata[`EIU_BIT_UNLOCK])
          begin
            // Select taken only with unlock written zero [R17]
            vec_sel_r <= reg_wdata[`EIU_BIT_VEC_SEL];
            unlock_r  <= 1'b0;
            tail_r    <= 1'b1;
            vstate_r  <= eiu_pkg::EIU_VS_TAIL;
          end
          else if (unlock_cnt_r == 3'h1)
          begin
            unlock_r <= 1'b0; // [R17]
            vstate_r <= eiu_pkg::EIU_VS_IDLE;
          end
          else
            unlock_cnt_r <= unlock_cnt_r - 3'h1;
        end
        eiu_pkg::EIU_VS_TAIL:
        begin
          // One more cycle covers the instruction after the write [R18]
          tail_r   <= 1'b0;
          vstate_r <= eiu_pkg::EIU_VS_IDLE;
        end
        default:
          // Unused encoding falls back to idle
          vstate_r <= eiu_pkg::EIU_VS_IDLE;
      endcase
    end
  end

  // Blocking leaves the global enable itself untouched [R18]
  assign irq_blocked         = unlock_r | tail_r;
  assign vector_table_select = vec_sel_r; // [R16]

  ////////////////////////////////////////////////////////////////////////
  // Vectored requests gated by enable, global flag and unlock block
  // Level mode requests straight from the synced pin, not the flag
  assign req_dedicated = ~irq_blocked & global_irq_enable & enable_mask_r[`EIU_BIT_DEDICATED]
                       & (low_level ? ~ded_sync_r : flag_ded_r); // [R10] [R5]
  assign pin_change_group_low_request = ~irq_blocked & global_irq_enable
                                      & enable_mask_r[`EIU_BIT_GROUP_LOW] & flag_low_r; // [R11]
  assign pin_change_group_high_request = ~irq_blocked & global_irq_enable
                                       & enable_mask_r[`EIU_BIT_GROUP_HIGH] & flag_high_r; // [R11]

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped reads return zero
  always_comb
  begin
    case (reg_addr)
      `EIU_OFS_ENABLE_MASK:   rdata_nxt = enable_mask_r;
      `EIU_OFS_SENSE_CONTROL: rdata_nxt = {6'h00, sense_r};
      `EIU_OFS_PC_MASK_LOW:   rdata_nxt = mask_low_r;
      `EIU_OFS_PC_MASK_HIGH:  rdata_nxt = mask_high_r;
      `EIU_OFS_FLAGS:         rdata_nxt = {flag_high_r, flag_low_r, 5'h00, flag_ded_r};
      `EIU_OFS_CORE_CONTROL:  rdata_nxt = {6'h00, vec_sel_r, unlock_r};
      default:                rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// ---- rtl/eiu_params.svh ----
/*
  Register offsets, field positions, reset values and timing counts
  for the external pin interrupt unit. Assumes inclusion by bare name.
*/
`ifndef EIU_PARAMS_SVH
`define EIU_PARAMS_SVH

// Register offsets on the plain register port
`define EIU_OFS_ENABLE_MASK   8'h3d
`define EIU_OFS_SENSE_CONTROL 8'h69
`define EIU_OFS_PC_MASK_LOW   8'h6b
`define EIU_OFS_PC_MASK_HIGH  8'h6c
`define EIU_OFS_FLAGS         8'h3c
`define EIU_OFS_CORE_CONTROL  8'h55

// Field positions
`define EIU_BIT_DEDICATED     0
`define EIU_BIT_GROUP_LOW     6
`define EIU_BIT_GROUP_HIGH    7
`define EIU_BIT_UNLOCK        0
`define EIU_BIT_VEC_SEL       1

// Reset values
`define EIU_RST_BYTE          8'h00

// Unlock window in cycles
`define EIU_UNLOCK_CYCLES     3'h4

`endif

// ---- rtl/eiu_pkg.sv ----
/*
  Types of the external pin interrupt unit.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package eiu_pkg;
  // Sense selections of the dedicated pin
  typedef enum logic [1:0]
  {
    EIU_SENSE_LOW     = 2'h0,
    EIU_SENSE_ANY     = 2'h1,
    EIU_SENSE_FALLING = 2'h2,
    EIU_SENSE_RISING  = 2'h3
  } eiu_sense_t;
  // Vector-change unlock sequence
  typedef enum logic [1:0] { EIU_VS_IDLE, EIU_VS_OPEN, EIU_VS_TAIL } eiu_vstate_t;
endpackage
`default_nettype wire

// ---- rtl/eiu_pc_if.sv ----
/*
  Bundle between the top and the pin-change group detector.
  Assumes one clock, ref_clk, shared by both ends.
*/
`default_nettype none
interface eiu_pc_if;
  logic [7:0] pins_sync;
  logic [7:0] mask;
  logic       group_enable;
  logic       async_wake;
  logic       toggle;
  modport det (input pins_sync, input mask, input group_enable,
               output async_wake, output toggle);
  modport top (output pins_sync, output mask, output group_enable,
               input async_wake, input toggle);
endinterface
`default_nettype wire

// ---- rtl/eiu_pc_group.sv ----
/*
  One group of eight pin-change inputs: masked toggle detection.
  Assumes pins already synchronised; raw pins used only for wake.
*/
`default_nettype none
module eiu_pc_group
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Raw pins for clockless wake detection
  input  wire logic [7:0] pins_raw,
  input  wire logic [7:0] pins_ref,
  // Detector bundle
  eiu_pc_if.det           pc
);
  logic [7:0] prev_r;

  ////////////////////////////////////////////////////////////////////////
  // Previous sample for toggle detection
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      prev_r <= 8'h00;
    else
      prev_r <= pc.pins_sync;
  end

  // Masked toggle, ORed over the group [R19] [R12] [R1]
  assign pc.toggle = pc.group_enable & |((pc.pins_sync ^ prev_r) & pc.mask);

  // Clockless compare of pins against last sampled value, for wake [R3]
  assign pc.async_wake = pc.group_enable & |((pins_raw ^ pins_ref) & pc.mask);
endmodule
`default_nettype wire

// ---- tb/eiu_properties.sv ----
/* Port checker of the pin interrupt unit.
   Assumes it is bound to eiu_top and shares its register header. */
`include "eiu_params.svh"
`default_nettype none
module eiu_properties
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // Pin and register port
  input wire logic       dedicated_irq_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  // Core side
  input wire logic       global_irq_enable,
  input wire logic       req_dedicated,
  input wire logic       pin_change_group_low_request,
  input wire logic       pin_change_group_high_request,
  input wire logic       vector_table_select,
  input wire logic       irq_blocked
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] en_r;
  logic [1:0] sense_r;
  logic       any_req;
  logic       ctl_wr;
  logic       sel_ok;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow enable and sense, since the checker sees only port traffic
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      en_r    <= 8'h00;
      sense_r <= 2'h0;
    end
    else if (reg_wr && reg_addr == `EIU_OFS_ENABLE_MASK)
      en_r <= reg_wdata & 8'hc1;
    else if (reg_wr && reg_addr == `EIU_OFS_SENSE_CONTROL)
      sense_r <= reg_wdata[1:0];
  end
  // Request summary and accepted select writes
  assign any_req = req_dedicated | pin_change_group_low_request | pin_change_group_high_request;
  assign ctl_wr  = reg_wr && reg_addr == `EIU_OFS_CORE_CONTROL;
  assign sel_ok  = ctl_wr && !reg_wdata[0] && irq_blocked;
  ////////////////////////////////////////////////////////////////////////////////
  property p_blocked_quiet; irq_blocked |-> !any_req; endproperty
  a_blocked_quiet: assert property (p_blocked_quiet) else $error("blocked req");
  property p_req_global; any_req |-> global_irq_enable; endproperty
  a_req_global: assert property (p_req_global) else $error("req no global");
  property p_ded_enable; req_dedicated |-> en_r[0]; endproperty
  a_ded_enable: assert property (p_ded_enable) else $error("ded req disabled");
  property p_low_enable; pin_change_group_low_request |-> en_r[6]; endproperty
  a_low_enable: assert property (p_low_enable) else $error("low req disabled");
  property p_high_enable; pin_change_group_high_request |-> en_r[7]; endproperty
  a_high_enable: assert property (p_high_enable) else $error("high req disabled");
  property p_unlock_sets; ctl_wr && reg_wdata[0] |=> irq_blocked; endproperty
  a_unlock_sets: assert property (p_unlock_sets) else $error("unlock not blocking");
  property p_unlock_bound; $rose(irq_blocked) |-> ##[1:5] !irq_blocked; endproperty
  a_unlock_bound: assert property (p_unlock_bound) else $error("block too long");
  property p_vsel_guard;
    $past(resetn) && $changed(vector_table_select) |-> $past(sel_ok);
  endproperty
  a_vsel_guard: assert property (p_vsel_guard) else $error("select unguarded");
  property p_level_req;
    sense_r == 2'h0 && en_r[0] && global_irq_enable && !irq_blocked && !dedicated_irq_pin
      && $past(!dedicated_irq_pin, 2) && $past(resetn) && $past(resetn, 2) |-> req_dedicated;
  endproperty
  a_level_req: assert property (p_level_req) else $error("level not requested");
endmodule
bind eiu_top eiu_properties u_props
(
  .ref_clk, .resetn, .dedicated_irq_pin, .reg_addr, .reg_wdata, .reg_wr,
  .global_irq_enable, .req_dedicated, .pin_change_group_low_request,
  .pin_change_group_high_request, .vector_table_select, .irq_blocked
);
`default_nettype wire

// ---- tb/eiu_core_model.sv ----
/* Core-side partner: services vector requests with ack pulses.
   Assumes request levels that drop once the flag is cleared. */
`default_nettype none
module eiu_core_model
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Service control
  input  wire logic       serve_on,
  input  wire logic [3:0] serve_dly,
  // Requests in, acknowledges out
  input  wire logic [2:0] req,
  output var  logic [2:0] ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r [3];
  // Prompt or slow service; one pulse, then a fresh wait and another pulse while request stays high
  always @(posedge ref_clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!resetn || !serve_on || !req[i] || ack[i])
      begin
        wait_r[i] <= 4'h0;
        ack[i]    <= 1'b0;
      end
      else
      begin
        wait_r[i] <= wait_r[i] + 4'h1;
        ack[i]    <= wait_r[i] == serve_dly;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/* Self-checking bench of the pin interrupt unit.
   Assumes the register header and a core partner model. */
`include "eiu_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk   = 1'b0;
  logic        resetn    = 1'b0;
  logic        ded_pin   = 1'b1;
  logic [15:0] pc_pins   = 16'h0000;
  logic [7:0]  addr      = 8'h00;
  logic [7:0]  wdata     = 8'h00;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        glob      = 1'b0;
  logic        serve_on  = 1'b0;
  logic [3:0]  serve_dly = 4'h0;
  logic [7:0]  rdata;
  wire  [2:0]  req;
  logic [2:0]  ack;
  logic        vsel;
  logic        blocked;
  logic        wake;
  int          miscompares = 0;
  int          tests_run   = 0;
  always #4 ref_clk = ~ref_clk;
  eiu_top u_dut
  (
    .ref_clk, .resetn, .dedicated_irq_pin(ded_pin), .pin_change_inputs(pc_pins),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .global_irq_enable(glob), .ack_dedicated(ack[0]), .ack_group_low(ack[1]),
    .ack_group_high(ack[2]), .req_dedicated(req[0]),
    .pin_change_group_low_request(req[1]), .pin_change_group_high_request(req[2]),
    .vector_table_select(vsel), .irq_blocked(blocked), .wake_request(wake)
  );
  eiu_core_model u_core (.ref_clk, .resetn, .serve_on, .serve_dly, .req, .ack);
  ////////////////////////////////////////////////////////////////////////////////
  // Compares, counted
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // Register port cycles
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk_byte(rdata, exp);
  endtask
  // Two sync edges and the flag edge
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, reserved bits, unmapped place
  task automatic t_regs;
    logic [7:0] a [5] = '{`EIU_OFS_ENABLE_MASK, `EIU_OFS_SENSE_CONTROL,
                          `EIU_OFS_PC_MASK_LOW, `EIU_OFS_PC_MASK_HIGH, 8'h00};
    logic [7:0] e [5] = '{8'hc1, 8'h03, 8'hff, 8'hff, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      expect_reg(a[i], 8'h00);
      reg_write(a[i], 8'hff);
      expect_reg(a[i], e[i]);
      reg_write(a[i], 8'h00);
    end
    expect_reg(`EIU_OFS_FLAGS, 8'h00);
    expect_reg(`EIU_OFS_CORE_CONTROL, 8'h00);
  endtask
  // Masked and enabled toggles; clear by write, then by prompt or slow service
  task automatic t_groups;
    for (int g = 0; g < 2; g++)
    begin
      reg_write(g ? `EIU_OFS_PC_MASK_HIGH : `EIU_OFS_PC_MASK_LOW, 8'h10);
      reg_write(`EIU_OFS_ENABLE_MASK, 8'h40 << g);
      @(posedge ref_clk);
      pc_pins <= pc_pins ^ (16'h0008 << 8 * g);
      #1 chk_bit(wake, 1'b0);
      settle();
      chk_byte({5'h00, req}, 8'h00);
      @(posedge ref_clk);
      pc_pins <= pc_pins ^ (16'h0010 << 8 * g);
      #1 chk_bit(wake, 1'b1);
      settle();
      chk_bit(wake, 1'b0);
      chk_byte({5'h00, req}, 8'h02 << g);
      expect_reg(`EIU_OFS_FLAGS, 8'h40 << g);
      reg_write(`EIU_OFS_FLAGS, 8'h40 << g);
      expect_reg(`EIU_OFS_FLAGS, 8'h00);
      @(posedge ref_clk);
      serve_on  <= 1'b1;
      serve_dly <= 4'(3 * g);
      pc_pins   <= pc_pins ^ (16'h0010 << 8 * g);
      settle();
      chk_byte({5'h00, req}, 8'h02 << g);
      repeat (6) @(posedge ref_clk);
      expect_reg(`EIU_OFS_FLAGS, 8'h00);
      @(posedge ref_clk);
      serve_on <= 1'b0;
    end
  endtask
  // Every sense mode against a fall and a rise
  task automatic t_sense;
    logic [3:0] on_fall = 4'b0111;
    logic [3:0] on_rise = 4'b1010;
    reg_write(`EIU_OFS_ENABLE_MASK, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      reg_write(`EIU_OFS_SENSE_CONTROL, 8'(m));
      reg_write(`EIU_OFS_FLAGS, 8'h01);
      @(posedge ref_clk);
      ded_pin <= 1'b0;
      #1 chk_bit(wake, m == 0);
      settle();
      chk_bit(req[0], on_fall[m]);
      expect_reg(`EIU_OFS_FLAGS, {7'h00, on_fall[m] && m != 0});
      chk_bit(req[0], on_fall[m]);
      reg_write(`EIU_OFS_FLAGS, 8'h01);
      @(posedge ref_clk);
      ded_pin <= 1'b1;
      settle();
      chk_bit(req[0], on_rise[m]);
    end
  endtask
  // Global flag, unlock window, select, expiry, unguarded write
  task automatic t_unlock;
    reg_write(`EIU_OFS_SENSE_CONTROL, 8'h02);
    reg_write(`EIU_OFS_FLAGS, 8'h01);
    @(posedge ref_clk);
    ded_pin <= 1'b0;
    glob    <= 1'b0;
    settle();
    chk_bit(req[0], 1'b0);
    expect_reg(`EIU_OFS_FLAGS, 8'h01);
    @(posedge ref_clk);
    glob <= 1'b1;
    #1 chk_bit(req[0], 1'b1);
    reg_write(`EIU_OFS_CORE_CONTROL, 8'h01);
    #1 chk_bit(req[0], 1'b0);
    reg_write(`EIU_OFS_CORE_CONTROL, 8'h02);
    #1 chk_bit(vsel, 1'b1);
    chk_bit(blocked, 1'b1);
    repeat (2) @(posedge ref_clk);
    #1 chk_bit(req[0], 1'b1);
    expect_reg(`EIU_OFS_CORE_CONTROL, 8'h02);
    reg_write(`EIU_OFS_CORE_CONTROL, 8'h01);
    repeat (3) @(posedge ref_clk);
    #1 chk_bit(blocked, 1'b1);
    @(posedge ref_clk);
    #1 chk_bit(blocked, 1'b0);
    reg_write(`EIU_OFS_CORE_CONTROL, 8'h00);
    #1 chk_bit(vsel, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after two reset cycles
  initial
  begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    glob   <= 1'b1;
    t_regs();
    t_groups();
    t_sense();
    t_unlock();
    complete_run();
  end
  // Watchdog; the sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
